// >>> logic/pointer_calendar_host_controller.v
// pointer and calendar host controller with its packet fifo
`timescale 1ns/10ps
`default_nettype none
`include "pointer_calendar_regs.vh"

// packet byte fifo between packet builder and output register
module packet_fifo #(
  parameter WIDTH  = 8,
  parameter DEPTH  = 16,
  parameter ADDR_W = 4
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
  reg [ADDR_W:0]  wr_ptr;          // extra bit tells full from empty
  reg [ADDR_W:0]  rd_ptr;
  wire            push;
  wire            pop;

  assign in_ready  = (wr_ptr[ADDR_W-1:0] != rd_ptr[ADDR_W-1:0]) ||
                     (wr_ptr[ADDR_W] == rd_ptr[ADDR_W]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[ADDR_W-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[ADDR_W-1:0]] <= in_data;
    end
  end

  // pointers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {(ADDR_W+1){1'b0}};
      rd_ptr <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// controller top
module pointer_calendar_host_controller #(
  parameter TIMER_CYCLES = `TIMER_PERIOD_US * 1000 / `CLK_PERIOD_NS,
  parameter FIFO_DEPTH   = 16
) (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire [9:0]  host_addr,
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [7:0]  host_wdata,
  output reg  [7:0]  host_rdata,
  output reg         host_irq,
  input  wire        x_phase_first,
  input  wire        x_phase_second,
  input  wire        y_phase_first,
  input  wire        y_phase_second,
  input  wire [2:0]  buttons_up,
  input  wire        cal_power_fail,
  output reg         cal_start,
  output reg         cal_write,
  output reg  [31:0] cal_wdata,
  input  wire        cal_done,
  input  wire [31:0] cal_rdata
);
  // service pacing, short enough to stay a local constant
  localparam integer SVC_FULL   = `SERVICE_PERIOD_US * 1000 / `CLK_PERIOD_NS;
  localparam [9:0]   SVC_CYCLES = SVC_FULL[9:0];
  // timer count cut to its counter width on purpose
  localparam [19:0]  TMR_LAST   = TIMER_CYCLES[19:0] - 20'h00001;

  // one quadrature step: 01 up, 11 down, 00 none or missed
  function [1:0] quad_step;
    input [1:0] prev;
    input [1:0] cur;
    begin
      case ({prev, cur})
        4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'h1;
        4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'h3;
        default: quad_step = 2'h0;
      endcase
    end
  endfunction

  reg         hold;          // host reset latch
  wire        core_rst_n;    // system reset or latch
  reg         out_full;      // output_full_flag
  reg         in_full;       // input_full_flag
  reg         command_flag;  // command port write not yet decoded
  reg         pwr_fail;      // sticky calendar power flag
  reg  [7:0]  out_reg;       // byte the host reads
  reg  [7:0]  in_reg;        // byte the host wrote
  reg  [7:0]  in_buf [0:4];  // command bytes
  reg  [2:0]  in_cnt;        // received byte counter
  reg  [7:0]  mot_thr;       // motion threshold, zero = off
  reg         btn_en;        // button reports on
  reg         tmr_en;        // timed reports on
  reg         cal_busy;      // calendar exchange running
  reg         primed;        // first sample taken
  reg  [2:0]  btn_prev;      // last button sample
  reg         btn_pend;      // button report owed
  reg         rt_pend;       // time answer owed
  reg  [31:0] rt_data;       // time bytes read back
  reg         timer_due;     // timed report owed
  reg  [19:0] tmr_cnt;       // report timer
  reg  [9:0]  svc_cnt;       // service pacing
  reg         sending;       // packet being pushed
  reg  [39:0] pkt;           // packet bytes, header on top
  reg  [2:0]  pkt_left;      // bytes still to push
  reg         acc_clear;     // clear accumulators
  wire [3:0]  phase;
  wire        svc_tick;
  wire        fifo_ready;
  wire [7:0]  fifo_data;
  wire        fifo_valid;
  wire        fifo_pop;
  wire        wr_data;
  wire        wr_cmd;
  wire        decode;
  wire        launch_ok;
  wire        motion_hit;
  wire        acc_any;
  wire [15:0] mag [0:1];
  wire [15:0] acc_val [0:1];
  wire [7:0]  status;
  integer     k;

  assign phase = {y_phase_second, y_phase_first, x_phase_second, x_phase_first};
  assign wr_data    = host_wr && (host_addr == `DATA_PORT_ADDR);
  assign wr_cmd     = host_wr && (host_addr == `CMD_PORT_ADDR);
  assign svc_tick   = (svc_cnt == SVC_CYCLES - 10'h001);
  assign decode     = command_flag && !in_full && !cal_busy;
  assign launch_ok  = !sending && !cal_busy;
  assign acc_any    = (acc_val[0] != 16'h0000) || (acc_val[1] != 16'h0000);
  assign motion_hit = (mot_thr != 8'h00) &&
                      ((mag[0] >= {8'h00, mot_thr}) || (mag[1] >= {8'h00, mot_thr}));
  assign fifo_pop   = svc_tick && !cal_busy && !out_full;
  assign status = {pwr_fail, buttons_up, command_flag, 1'b0, in_full, out_full};

  // reset latch, cleared by system reset or by a write to the clear port
  // reset latch ports
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold <= 1'b0;
    end else if (host_wr && host_addr == `RESET_SET_ADDR) begin
      hold <= 1'b1;
    end else if (host_wr && host_addr == `RESET_CLEAR_ADDR) begin
      hold <= 1'b0;
    end
  end
  // latch comes from a flop, so the combined reset is glitch free
  assign core_rst_n = rstn & ~hold;

  // host read data, registered one cycle after the strobe
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= `RESET_STATUS;
    end else if (host_rd) begin
      case (host_addr)
        `DATA_PORT_ADDR: host_rdata <= out_reg;
        `CMD_PORT_ADDR:  host_rdata <= status;
        default:         host_rdata <= 8'h00;
      endcase
    end
  end

  // per axis quadrature decode and accumulator
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : axis
      reg        [1:0]  prev; // last phase pair
      reg signed [15:0] acc;  // signed tick sum
      wire       [1:0]  step;
      assign step = primed ? quad_step(prev, phase[2*i+1:2*i]) : 2'h0;
      assign acc_val[i] = acc;
      assign mag[i] = acc[15] ? (16'h0000 - acc) : acc;
      always @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
          prev <= 2'h0;
          acc  <= 16'h0000;
        end else begin
          prev <= phase[2*i+1:2*i];
          if (acc_clear) begin
            acc <= (step == 2'h1) ? 16'h0001 : ((step == 2'h3) ? 16'hFFFF : 16'h0000);
          end else if (step == 2'h1 && acc != `ACC_LIMIT) begin
            acc <= acc + 16'sh0001;
          end else if (step == 2'h3 && acc != (16'h0000 - `ACC_LIMIT)) begin
            acc <= acc - 16'sh0001;
          end
        end
      end
    end
  endgenerate

  // host input path and command decode
  always @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      in_full      <= 1'b0;
      command_flag <= 1'b0;
      in_reg       <= 8'h00;
      in_cnt       <= 3'h0;
      for (k = 0; k < 5; k = k + 1) begin
        in_buf[k] <= 8'h00;
      end
      mot_thr   <= 8'h00;
      btn_en    <= 1'b0;
      tmr_en    <= 1'b0;
      cal_start <= 1'b0;
      cal_write <= 1'b0;
      cal_wdata <= 32'h00000000;
    end else begin
      cal_start <= 1'b0;
      if (in_full && !cal_busy) begin
        if (in_cnt < 3'h5) begin
          in_buf[in_cnt] <= in_reg;
        end
        // counter saturates so an overlong command mismatches
        if (in_cnt != 3'h6) begin
          in_cnt <= in_cnt + 3'h1;
        end
        in_full <= 1'b0;
      end
      if (decode) begin
        case (in_buf[0])
          `HDR_SET_TIME: if (in_cnt == `LEN_SET_TIME) begin
            cal_start <= 1'b1;
            cal_write <= 1'b1;
            cal_wdata <= {in_buf[1], in_buf[2], in_buf[3], in_buf[4]};
          end
          `HDR_READ_TIME: if (in_cnt == `LEN_READ_TIME) begin
            cal_start <= 1'b1;
            cal_write <= 1'b0;
          end
          `HDR_MOTION: if (in_cnt == `LEN_ONE_ARG) begin
            mot_thr <= in_buf[1];
          end
          `HDR_BUTTON: if (in_cnt == `LEN_ONE_ARG) begin
            btn_en <= (in_buf[1] != 8'h00);
          end
          `HDR_TIMER: if (in_cnt == `LEN_ONE_ARG) begin
            tmr_en <= (in_buf[1] != 8'h00);
          end
          // unknown header discards
          default: begin
          end
        endcase
        in_cnt <= 3'h0;
      end
      // a new write wins over the move and over the cleanup
      if (wr_data || wr_cmd) begin
        in_reg  <= host_wdata;
        in_full <= 1'b1;
      end
      if (wr_cmd) begin
        command_flag <= 1'b1;
      end else if (decode) begin
        command_flag <= 1'b0;
      end
    end
  end

  // calendar exchange and power flag
  always @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cal_busy <= 1'b0;
      pwr_fail <= 1'b0;
      rt_data  <= 32'h00000000;
    end else begin
      if (cal_start) begin
        cal_busy <= 1'b1;
      end else if (cal_done && cal_busy) begin
        cal_busy <= 1'b0;
      end
      if (cal_done && cal_busy && !cal_write) begin
        rt_data <= cal_rdata;
      end
      if (cal_power_fail) begin
        pwr_fail <= 1'b1;
      end else if (cal_done && cal_busy && cal_write) begin
        pwr_fail <= 1'b0;
      end
    end
  end

  // event watching, timer and packet builder
  always @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      primed    <= 1'b0;
      btn_prev  <= 3'h0;
      btn_pend  <= 1'b0;
      rt_pend   <= 1'b0;
      timer_due <= 1'b0;
      tmr_cnt   <= 20'h00000;
      sending   <= 1'b0;
      pkt       <= 40'h0000000000;
      pkt_left  <= 3'h0;
      acc_clear <= 1'b0;
    end else begin
      primed    <= 1'b1;
      btn_prev  <= buttons_up;
      acc_clear <= 1'b0;
      // report timer free runs; due only counts when enabled
      if (tmr_cnt == TMR_LAST) begin
        tmr_cnt <= 20'h00000;
      end else begin
        tmr_cnt <= tmr_cnt + 20'h00001;
      end
      // push one byte whenever the fifo takes it
      if (sending && fifo_ready) begin
        pkt <= {pkt[31:0], 8'h00};
        pkt_left <= pkt_left - 3'h1;
        if (pkt_left == 3'h1) begin
          sending <= 1'b0;
        end
      end
      if (launch_ok) begin
        if (rt_pend) begin
          pkt      <= {`PKT_TIME, rt_data};
          pkt_left <= 3'h5;
          sending  <= 1'b1;
        end else if (motion_hit) begin
          pkt       <= {`PKT_MOTION, acc_val[0], acc_val[1]};
          pkt_left  <= 3'h5;
          sending   <= 1'b1;
          acc_clear <= 1'b1;
        end else if (btn_pend) begin
          pkt      <= {`PKT_BUTTON, 32'h00000000};
          pkt_left <= 3'h1;
          sending  <= 1'b1;
        end else if (timer_due && acc_any) begin
          pkt       <= {`PKT_TIMED, acc_val[0], acc_val[1]};
          pkt_left  <= 3'h5;
          sending   <= 1'b1;
          acc_clear <= 1'b1;
        end
      end
      // owed flags: a new event wins over its clear
      if (cal_done && cal_busy && !cal_write) begin
        rt_pend <= 1'b1;
      end else if (launch_ok) begin
        rt_pend <= 1'b0;
      end
      if (btn_en && primed && (buttons_up != btn_prev)) begin
        btn_pend <= 1'b1;
      end else if (launch_ok && !rt_pend && !motion_hit) begin
        btn_pend <= 1'b0;
      end
      if (tmr_en && tmr_cnt == TMR_LAST) begin
        timer_due <= 1'b1;
      end else if (launch_ok && !rt_pend && !motion_hit && !btn_pend) begin
        timer_due <= 1'b0;
      end
    end
  end

  packet_fifo #(
    .WIDTH  (8),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W ($clog2(FIFO_DEPTH))
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (core_rst_n),
    .in_data   (pkt[39:32]),
    .in_valid  (sending),
    .in_ready  (fifo_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // output register service once per processing cycle
  always @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      svc_cnt  <= 10'h000;
      out_full <= 1'b0;
      out_reg  <= 8'h00;
      host_irq <= 1'b0;
    end else begin
      host_irq <= 1'b0;
      if (svc_tick) begin
        svc_cnt <= 10'h000;
      end else begin
        svc_cnt <= svc_cnt + 10'h001;
      end
      if (svc_tick && !cal_busy) begin
        if (out_full) begin
          host_irq <= 1'b1;
        end else if (fifo_valid) begin
          out_reg  <= fifo_data;
          out_full <= 1'b1;
          host_irq <= 1'b1;
        end
      end
      if (host_rd && host_addr == `DATA_PORT_ADDR && out_full) begin
        out_full <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/pointer_calendar_regs.vh
// constants of the pointer and calendar host controller
// Notes on behaviour
// - status shows output full, input full, command
// - status shows buttons up and calendar power
// - command port write acts as data write
// - set time loads four bcd bytes
// - read time answers with packet R
// - motion threshold 1-255, zero disables, packet M
// - button reports on or off, packet B
// - timer reports A about 40 per second
// - each write moves byte, bumps counter
// - command flag triggers decode, length check, cleanup
// - interrupt line pulsed toward host
// - header load sets output full, signals
// - each cycle resignal, load next, or idle
// - packet bytes: header then four data bytes, button packet B header only
// - calendar commands suspend other activity
// - set time clears power fail if sound
// - reset clears everything, loads defaults
// - quadrature steps into clamped signed accumulators
// - reports copy then clear the accumulators
`ifndef POINTER_CALENDAR_REGS_VH
`define POINTER_CALENDAR_REGS_VH
// host i/o port addresses
`define DATA_PORT_ADDR    10'h2FC
`define CMD_PORT_ADDR     10'h2FE
`define RESET_SET_ADDR    10'h2FF
`define RESET_CLEAR_ADDR  10'h2FD
// status byte field positions
`define ST_OUT_FULL       0
`define ST_IN_FULL        1
`define ST_SPARE          2
`define ST_CMD            3
`define ST_BTN_LO         4
`define ST_PWR_FAIL       7
// command headers and their total byte counts
`define HDR_SET_TIME      8'h01
`define HDR_READ_TIME     8'h02
`define HDR_MOTION        8'h08
`define HDR_BUTTON        8'h10
`define HDR_TIMER         8'h20
`define LEN_SET_TIME      3'h5
`define LEN_READ_TIME     3'h1
`define LEN_ONE_ARG       3'h2
// packet headers
`define PKT_TIME          8'h52
`define PKT_MOTION        8'h4D
`define PKT_BUTTON        8'h42
`define PKT_TIMED         8'h41
// accumulator limit
`define ACC_LIMIT         16'h7FDF
// timing
`define CLK_PERIOD_NS     50
`define TIMER_PERIOD_US   25000
`define SERVICE_PERIOD_US 50
`define RESET_STATUS      8'h00
`endif

// >>> sim/cal_model.sv
// calendar side model answering each start with a done pulse
`timescale 1ns/10ps
`default_nettype none
module cal_model #(
  parameter int DELAY = 40  // slow answer, in clock cycles
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        cal_start,
  input  wire logic        cal_write,
  input  wire logic [31:0] cal_wdata,
  output var  logic        cal_done,
  output var  logic [31:0] cal_rdata
);
  logic [31:0] stored;  // minute hour day month
  int          left;    // cycles left in the exchange
  logic        fast;    // alternate prompt and slow answers
  // one exchange at a time; read data is only meaningful with done
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cal_done  <= 1'b0;
      cal_rdata <= 32'h0;
      stored    <= 32'h0;
      left      <= 0;
      fast      <= 1'b0;
    end else begin
      cal_done  <= 1'b0;
      // released lines toggle so stale data is never mistaken
      cal_rdata <= ~cal_rdata;
      if (cal_start) begin
        left <= fast ? 2 : DELAY;
        fast <= !fast;
      end else if (left != 0) begin
        left <= left - 1;
        if (left == 1) begin
          cal_done <= 1'b1;
          if (cal_write) begin
            stored <= cal_wdata;
          end
          cal_rdata <= cal_write ? cal_wdata : stored;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/pch_checker_asserts.sv
// port checker for the pointer calendar host controller
`timescale 1ns/10ps
`default_nettype none
module pch_checker (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [9:0]  host_addr,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [7:0]  host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_irq,
  input wire logic [2:0]  buttons_up,
  input wire logic        cal_start,
  input wire logic        cal_write,
  input wire logic [31:0] cal_wdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire         rd_st  = host_rd && host_addr == 10'h2FE;  // status read
  wire         rd_dat = host_rd && host_addr == 10'h2FC;  // data read
  wire         wr_cmd = host_wr && host_addr == 10'h2FE;  // command write
  wire         wr_dat = host_wr && host_addr == 10'h2FC;  // data write
  logic [7:0]  hdr;      // first byte of the command in flight
  logic        in_cmd;   // a data byte opened a command
  logic [31:0] tail;     // last four bytes written
  logic [10:0] gap;      // cycles since the last interrupt
  logic [2:0]  age;      // cycles the buttons stood still
  logic [2:0]  btn_old;  // buttons one cycle ago
  // helper state from port traffic; counters saturate so they never wrap
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hdr     <= 8'h00;
      in_cmd  <= 1'b0;
      tail    <= 32'h0;
      gap     <= 11'h7FF;
      age     <= 3'h0;
      btn_old <= 3'h0;
    end else begin
      if (wr_cmd || wr_dat) begin
        if (!in_cmd) begin
          hdr <= host_wdata;
        end
        in_cmd <= wr_dat;
        tail   <= {tail[23:0], host_wdata};
      end
      gap     <= host_irq ? 11'h000 : (gap == 11'h7FF ? gap : gap + 11'h001);
      age     <= (buttons_up != btn_old) ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
      btn_old <= buttons_up;
    end
  end
  a_spare_zero: assert property (rd_st |=> !host_rdata[2])
    else $error("status spare bit set");
  a_cmd_flags: assert property (wr_cmd ##1 rd_st |=> host_rdata[3] && host_rdata[1])
    else $error("command write not flagged");
  a_data_flags: assert property (wr_dat ##1 rd_st |=> host_rdata[1] && !host_rdata[3])
    else $error("data write flags wrong");
  a_read_clears: assert property (rd_dat ##1 !host_irq ##1 (rd_st && !host_irq) |=> !host_rdata[0])
    else $error("output full after data read");
  a_btn_status: assert property (rd_st && age == 3'h7 |=> host_rdata[6:4] == $past(buttons_up))
    else $error("button bits differ from inputs");
  a_irq_gap: assert property (host_irq |-> gap >= 11'h3E7)
    else $error("interrupt pulses too close");
  a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved without a read");
  a_start_pulse: assert property (cal_start |=> !cal_start)
    else $error("calendar start longer than one cycle");
  a_cal_kind: assert property (cal_start |-> cal_write == (hdr == 8'h01))
    else $error("calendar exchange of wrong kind");
  a_cal_data: assert property (cal_start && cal_write |-> cal_wdata == tail)
    else $error("calendar data differs from bytes sent");
  a_read_start: assert property (wr_cmd && !in_cmd && host_wdata == 8'h02 |-> ##[2:8] cal_start)
    else $error("read time did not start an exchange");
endmodule
bind pointer_calendar_host_controller pch_checker i_chk (
  .ref_clk   (ref_clk),
  .rstn      (rstn),
  .host_addr (host_addr),
  .host_wr   (host_wr),
  .host_rd   (host_rd),
  .host_wdata(host_wdata),
  .host_rdata(host_rdata),
  .host_irq  (host_irq),
  .buttons_up(buttons_up),
  .cal_start (cal_start),
  .cal_write (cal_write),
  .cal_wdata (cal_wdata)
);
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the pointer calendar host controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        ref_clk;
  logic        rstn;
  logic [9:0]  host_addr;
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_wdata;
  logic [7:0]  host_rdata;
  logic        host_irq;
  logic [1:0]  xq;              // x phases first, second
  logic [1:0]  yq;              // y phases first, second
  logic [2:0]  buttons_up;
  logic        cal_power_fail;
  logic        cal_start;
  logic        cal_write;
  logic [31:0] cal_wdata;
  logic        cal_done;
  logic [31:0] cal_rdata;
  logic [7:0]  exp_q[$];        // expected read bytes, oldest first
  logic        chk_d = 1'b0;    // a checked read was taken last edge
  logic        want;            // current read is compared
  logic [7:0]  rv;              // last byte read
  logic [15:0] dx;
  logic [15:0] dy;
  logic [31:0] seed;
  int          err_count;
  int          num_checks;
  int          cycles = 0;
  pointer_calendar_host_controller #(.TIMER_CYCLES(200), .FIFO_DEPTH(16)) i_dut (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .host_addr     (host_addr),
    .host_wr       (host_wr),
    .host_rd       (host_rd),
    .host_wdata    (host_wdata),
    .host_rdata    (host_rdata),
    .host_irq      (host_irq),
    .x_phase_first (xq[1]),
    .x_phase_second(xq[0]),
    .y_phase_first (yq[1]),
    .y_phase_second(yq[0]),
    .buttons_up    (buttons_up),
    .cal_power_fail(cal_power_fail),
    .cal_start     (cal_start),
    .cal_write     (cal_write),
    .cal_wdata     (cal_wdata),
    .cal_done      (cal_done),
    .cal_rdata     (cal_rdata)
  );
  cal_model #(.DELAY(40)) i_cal (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .cal_start(cal_start),
    .cal_write(cal_write),
    .cal_wdata(cal_wdata),
    .cal_done (cal_done),
    .cal_rdata(cal_rdata)
  );
  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watcher: each checked read is compared with the oldest note
  always @(posedge ref_clk) begin
    if (chk_d) begin
      num_checks++;
      if (exp_q.size() == 0) begin
        fail("read without a note");
      end else if (host_rdata !== exp_q[0]) begin
        fail($sformatf("read %h want %h", host_rdata, exp_q[0]));
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
      end
    end
    chk_d <= host_rd && want;
  end
  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail("run too long");
      end_sim;
    end
  end
  // one read cycle; starts and ends just after a rising edge
  task automatic rd(input logic [9:0] a, input logic c, input logic [7:0] e);
    if (c) begin
      exp_q.push_back(e);
    end
    want      <= c;
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    @(negedge ref_clk);
    rv = host_rdata;
    @(posedge ref_clk);
  endtask
  // read status until bit b shows v, bounded
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    rd(10'h2FE, 1'b0, 8'h00);
    while (rv[b] !== v && n < 3000) begin
      rd(10'h2FE, 1'b0, 8'h00);
      n++;
    end
    if (n == 3000) begin
      fail("status flag stuck");
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    poll(1, 1'b0);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
  endtask
  // command of n bytes, left-justified in v
  task automatic send(input int n, input logic [39:0] v);
    for (int i = 0; i < n; i++) begin
      wr(i == n - 1 ? 10'h2FE : 10'h2FC, v[39 - 8 * i -: 8]);
    end
  endtask
  // wait for output full, then take one byte
  task automatic get(input logic c, input logic [7:0] e);
    poll(0, 1'b1);
    rd(10'h2FC, c, e);
  endtask
  // header then both deltas; step direction is free, so size only
  task automatic pkt(input logic [7:0] h, input logic [15:0] mx, input logic [15:0] my);
    get(1'b1, h);
    get(1'b0, 8'h00);
    dx[15:8] = rv;
    get(1'b0, 8'h00);
    dx[7:0] = rv;
    get(1'b0, 8'h00);
    dy[15:8] = rv;
    get(1'b0, 8'h00);
    dy[7:0] = rv;
    num_checks++;
    if (!((dx === mx || dx === -mx) && (dy === my || dy === -my))) begin
      fail("delta size wrong");
    end
  endtask
  // n gray-code steps on one axis
  task automatic step(input logic ax, input int n);
    logic [1:0] g;
    for (int i = 0; i < n; i++) begin
      g = ax ? yq : xq;
      g = {g[0], ~g[1]};
      if (ax) begin
        yq <= g;
      end else begin
        xq <= g;
      end
      repeat (4) @(posedge ref_clk);
    end
  endtask
  // main sequence
  initial begin
    rstn           = 1'b0;
    host_addr      = 10'h000;
    host_wr        = 1'b0;
    host_rd        = 1'b0;
    host_wdata     = 8'h00;
    xq             = 2'h0;
    yq             = 2'h0;
    buttons_up     = 3'h7;
    cal_power_fail = 1'b0;
    want           = 1'b0;
    err_count      = 0;
    num_checks     = 0;
    seed           = 32'h198F;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(10'h2FE, 1'b1, 8'h70);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      buttons_up <= seed[2:0];
      repeat (10) @(posedge ref_clk);
      rd(10'h2FE, 1'b1, {1'b0, seed[2:0], 4'h0});
    end
    cal_power_fail <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cal_power_fail <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(10'h2FE, 1'b1, {1'b1, buttons_up, 4'h0});
    send(2, {8'h08, 8'h03, 24'h0});
    step(1'b0, 3);
    pkt(8'h4D, 16'h0003, 16'h0000);
    step(1'b1, 2);
    send(2, {8'h08, 8'h00, 24'h0});
    send(2, {8'h20, 8'h01, 24'h0});
    pkt(8'h41, 16'h0000, 16'h0002);
    send(2, {8'h20, 8'h00, 24'h0});
    send(2, {8'h10, 8'hFF, 24'h0});
    // the enable lands two edges after the last write
    repeat (4) @(posedge ref_clk);
    buttons_up <= buttons_up ^ 3'h2;
    get(1'b1, 8'h42);
    send(2, {8'h10, 8'h00, 24'h0});
    send(5, {8'h01, 8'h59, 8'h23, 8'h31, 8'h12});
    // let the slow set-time exchange finish first
    repeat (60) @(posedge ref_clk);
    send(1, {8'h02, 32'h0});
    get(1'b1, 8'h52);
    get(1'b1, 8'h59);
    get(1'b1, 8'h23);
    get(1'b1, 8'h31);
    get(1'b1, 8'h12);
    rd(10'h2FE, 1'b1, {1'b0, buttons_up, 4'h0});
    send(1, {8'h20, 32'h0});
    step(1'b0, 1);
    repeat (2500) @(posedge ref_clk);
    rd(10'h2FE, 1'b1, {1'b0, buttons_up, 4'h0});
    // latch reset in mid-run clears the sticky power flag
    cal_power_fail <= 1'b1;
    @(posedge ref_clk);
    cal_power_fail <= 1'b0;
    wr(10'h2FF, 8'h00);
    wr(10'h2FD, 8'h00);
    rd(10'h2FE, 1'b1, {1'b0, buttons_up, 4'h0});
    // let the watcher take the last note
    @(posedge ref_clk);
    end_sim;
  end
endmodule
`default_nettype wire
